// ==== hw/mbs_accum.sv ====
`timescale 1ns/1ps
module mbs_accum (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  mbs_rd_if.acc    rd
);
  typedef struct packed {
    logic [mbs_pkg::SUM_W-1:0] sum;
  } mbs_acc_st_t;

  mbs_acc_st_t st_q;
  mbs_acc_st_t st_d;
  logic [mbs_pkg::WORD_W-1:0] masked;
  logic [mbs_pkg::SUM_W-1:0]  byte_add;

  always_comb begin
    st_d     = st_q;
    masked   = rd.data & rd.mask; // [R4] [R5]
    byte_add = mbs_pkg::SUM_RST;
    if (rd.word_mode) begin
      for (int i = 0; i < mbs_pkg::WORD_W / mbs_pkg::BYTE_W; i++) begin
        byte_add = byte_add + {24'h000000, masked[i*8 +: 8]}; // [R4] [R5]
      end
    end else begin
      byte_add = {24'h000000, rd.data[7:0]}; // [R1] [R2]
    end
    if (rd.clear) st_d.sum = mbs_pkg::SUM_RST;
    else if (rd.valid) st_d.sum = st_q.sum + byte_add; // [R10]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) st_q <= '{sum: mbs_pkg::SUM_RST};
    else if (ce) st_q <= st_d;
  end
  assign rd.sum = st_q.sum;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_word_add;
    @(posedge ref_clk) disable iff (rst)
    (ce && rd.valid && rd.word_mode && !rd.clear)
      |=> rd.sum == $past(rd.sum) + {24'h0, $past(masked[7:0])}
          + {24'h0, $past(masked[15:8])} + {24'h0, $past(masked[23:16])}
          + {24'h0, $past(masked[31:24])};
  endproperty
  a_word_add: assert property (p_word_add) // [R4] [R5]
    else $error("masked word bytes not added to running sum");
endmodule : mbs_accum

// ==== hw/mbs_checksum.sv ====
// Summary of operation
// R1 - every program flash byte is added unsigned into a 32-bit sum.
// R2 - every boot flash byte except the config words is added likewise.
// R3 - the last 16 boot bytes are the four config words, masked instead.
// R4 - each config word is ANDed with its mask and its four bytes summed.
// R5 - the identity word is ANDed with its mask and its four bytes summed.
// R6 - the checksum is the two's complement of the total of all sums.
// R7 - two's complement is invert then add one, carry beyond bit 31 lost.
// R8 - a code-protected part reports a checksum of zero.
// R9 - masks hold ones on implemented bits and zeros elsewhere.
// R10 - all sums wrap mod 2^32 and masks are per-part parameters.
`timescale 1ns/1ps
module mbs_checksum #(
  parameter int unsigned PROG_BYTES = mbs_pkg::PROG_BYTES_DEF,
  parameter int unsigned BOOT_BYTES = mbs_pkg::BOOT_BYTES_DEF,
  // implemented-bit masks, per part [R9] [R10]
  parameter logic [31:0] CFG0_MASK  = mbs_pkg::MASK_DEF,
  parameter logic [31:0] CFG1_MASK  = mbs_pkg::MASK_DEF,
  parameter logic [31:0] CFG2_MASK  = mbs_pkg::MASK_DEF,
  parameter logic [31:0] CFG3_MASK  = mbs_pkg::MASK_DEF,
  parameter logic [31:0] IDENT_MASK = mbs_pkg::MASK_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        code_protected,
  output logic             mem_req,
  output logic             mem_word,
  output logic [31:0]      mem_index,
  input  wire logic        mem_valid,
  input  wire logic [31:0] mem_data,
  output logic             busy,
  output logic             done,
  output logic [31:0]      checksum
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mbs_pkg::mbs_state_t st;
    logic [31:0]         idx;
    logic                req;
    logic                word;
    logic                prot;
    logic                busy;
    logic                done;
    logic [31:0]         cks;
  } mbs_top_st_t;

  mbs_top_st_t s_q;
  mbs_top_st_t s_d;
  mbs_rd_if    rd ();

  localparam logic [31:0] PROG_LAST = 32'(PROG_BYTES - 1);
  localparam logic [31:0] BOOT_LAST =
    32'(BOOT_BYTES - mbs_pkg::CFG_BYTES - 1); // [R3]
  localparam logic [31:0] CFG_LAST  = 32'(mbs_pkg::CFG_WORDS - 1);

  function automatic logic [31:0] cfg_mask(input logic [31:0] i);
    case (i[1:0])
      2'h0:    cfg_mask = CFG0_MASK;
      2'h1:    cfg_mask = CFG1_MASK;
      2'h2:    cfg_mask = CFG2_MASK;
      default: cfg_mask = CFG3_MASK;
    endcase
  endfunction : cfg_mask

  mbs_accum u_acc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .rd      (rd)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one running sum serves all four partial sums: mod 2^32 addition is
  // associative, so the total is identical and area is a quarter
  always_comb begin
    s_d          = s_q;
    rd.clear     = 1'b0;
    rd.valid     = 1'b0;
    rd.word_mode = s_q.word;
    rd.data      = mem_data;
    rd.mask      = (s_q.st == mbs_pkg::MBS_IDENT) ? IDENT_MASK
                                                  : cfg_mask(s_q.idx);
    s_d.done     = 1'b0;
    case (s_q.st)
      mbs_pkg::MBS_IDLE: begin
        if (start) begin
          rd.clear = 1'b1;
          s_d.prot = code_protected;
          s_d.st   = mbs_pkg::MBS_PROG;
          s_d.idx  = mbs_pkg::SUM_RST;
          s_d.req  = 1'b1;
          s_d.word = 1'b0;
          s_d.busy = 1'b1;
        end
      end
      mbs_pkg::MBS_PROG, mbs_pkg::MBS_BOOT,
      mbs_pkg::MBS_CFG, mbs_pkg::MBS_IDENT: begin
        if (mem_valid) begin
          rd.valid = 1'b1; // [R1] [R2] [R4] [R5]
          s_d.idx  = s_q.idx + mbs_pkg::SUM_ONE;
          if (s_q.st == mbs_pkg::MBS_PROG && s_q.idx == PROG_LAST) begin
            s_d.st  = mbs_pkg::MBS_BOOT;
            s_d.idx = mbs_pkg::SUM_RST;
          end else if (s_q.st == mbs_pkg::MBS_BOOT &&
                       s_q.idx == BOOT_LAST) begin
            s_d.st   = mbs_pkg::MBS_CFG; // [R3]
            s_d.idx  = mbs_pkg::SUM_RST;
            s_d.word = 1'b1;
          end else if (s_q.st == mbs_pkg::MBS_CFG &&
                       s_q.idx == CFG_LAST) begin
            s_d.st  = mbs_pkg::MBS_IDENT;
            s_d.idx = mbs_pkg::SUM_RST;
          end else if (s_q.st == mbs_pkg::MBS_IDENT) begin
            s_d.st  = mbs_pkg::MBS_DONE;
            s_d.req = 1'b0;
          end
        end
      end
      mbs_pkg::MBS_DONE: begin
        // invert and add one, carry dropped [R6] [R7]
        s_d.cks  = s_q.prot ? mbs_pkg::SUM_RST // [R8]
                            : (~rd.sum + mbs_pkg::SUM_ONE);
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.word = 1'b0;
        s_d.st   = mbs_pkg::MBS_IDLE;
      end
      default: s_d.st = mbs_pkg::MBS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{st: mbs_pkg::MBS_IDLE, idx: mbs_pkg::SUM_RST, req: 1'b0,
               word: 1'b0, prot: 1'b0,
               busy: 1'b0, done: 1'b0, cks: mbs_pkg::SUM_RST};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign mem_req   = s_q.req;
  assign mem_word  = s_q.word;
  assign mem_index = s_q.idx;
  assign busy      = s_q.busy;
  assign done      = s_q.done;
  assign checksum  = s_q.cks;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_prot_zero;
    @(posedge ref_clk) disable iff (rst)
    (ce && s_q.st == mbs_pkg::MBS_DONE && s_q.prot) |=> checksum == 32'h0;
  endproperty
  a_prot_zero: assert property (p_prot_zero) // [R8]
    else $error("protected part gave nonzero checksum");

  property p_twos;
    @(posedge ref_clk) disable iff (rst)
    (ce && s_q.st == mbs_pkg::MBS_DONE && !s_q.prot)
      |=> checksum + $past(rd.sum) == 32'h0;
  endproperty
  a_twos: assert property (p_twos) // [R6] [R7]
    else $error("checksum not twos complement of total");

  property p_cfg_entry;
    @(posedge ref_clk) disable iff (rst)
    (ce && mem_valid && s_q.st == mbs_pkg::MBS_BOOT && s_q.idx == BOOT_LAST)
      |=> mem_word && s_q.st == mbs_pkg::MBS_CFG;
  endproperty
  a_cfg_entry: assert property (p_cfg_entry) // [R3]
    else $error("config words not entered after boot bytes");

  property p_byte_add;
    @(posedge ref_clk) disable iff (rst)
    (ce && rd.valid && !rd.word_mode && !rd.clear)
      |=> rd.sum == $past(rd.sum) + {24'h0, $past(mem_data[7:0])};
  endproperty
  a_byte_add: assert property (p_byte_add) // [R1] [R2]
    else $error("byte not added to running sum");

  property p_done_pulse;
    @(posedge ref_clk) disable iff (rst)
    (ce && done) |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // [R6]
    else $error("done held longer than one cycle");

  property p_start_take;
    @(posedge ref_clk) disable iff (rst)
    (ce && s_q.st == mbs_pkg::MBS_IDLE && start)
      |=> busy && mem_req && !mem_word && mem_index == mbs_pkg::SUM_RST;
  endproperty
  a_start_take: assert property (p_start_take) // [R1]
    else $error("run did not open on program byte zero");

  property p_prot_capture;
    @(posedge ref_clk) disable iff (rst)
    (ce && s_q.st == mbs_pkg::MBS_IDLE && start)
      |=> s_q.prot == $past(code_protected);
  endproperty
  a_prot_capture: assert property (p_prot_capture) // [R8]
    else $error("protection state not captured at start");

  property p_boot_entry;
    @(posedge ref_clk) disable iff (rst)
    (ce && mem_valid && s_q.st == mbs_pkg::MBS_PROG && s_q.idx == PROG_LAST)
      |=> s_q.st == mbs_pkg::MBS_BOOT && !mem_word
          && mem_index == mbs_pkg::SUM_RST;
  endproperty
  a_boot_entry: assert property (p_boot_entry) // [R2]
    else $error("boot bytes not entered after program bytes");

  property p_ident_entry;
    @(posedge ref_clk) disable iff (rst)
    (ce && mem_valid && s_q.st == mbs_pkg::MBS_CFG && s_q.idx == CFG_LAST)
      |=> s_q.st == mbs_pkg::MBS_IDENT && mem_word
          && mem_index == mbs_pkg::SUM_RST;
  endproperty
  a_ident_entry: assert property (p_ident_entry) // [R5]
    else $error("identity word not entered after config words");

  property p_ident_last;
    @(posedge ref_clk) disable iff (rst)
    (ce && mem_valid && s_q.st == mbs_pkg::MBS_IDENT)
      |=> !mem_req && s_q.st == mbs_pkg::MBS_DONE;
  endproperty
  a_ident_last: assert property (p_ident_last) // [R6]
    else $error("reads not closed after identity word");
endmodule : mbs_checksum

// ==== hw/mbs_pkg.sv ====
package mbs_pkg;
  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int unsigned SUM_W     = 32;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned CFG_WORDS = 4;
  localparam int unsigned CFG_BYTES = 16;
  localparam int unsigned BYTE_SEL_W = 2;
  localparam int unsigned CFG_SEL_W  = 2;
  localparam int unsigned PROG_BYTES_DEF = 524288;
  localparam int unsigned BOOT_BYTES_DEF = 12288;
  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [SUM_W-1:0]  SUM_RST  = 32'h0000_0000;
  localparam logic [SUM_W-1:0]  SUM_ONE  = 32'h0000_0001;
  localparam logic [WORD_W-1:0] MASK_DEF = 32'hffff_ffff;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    MBS_IDLE, MBS_PROG, MBS_BOOT, MBS_CFG, MBS_IDENT, MBS_DONE
  } mbs_state_t;
endpackage : mbs_pkg

// ==== hw/mbs_rd_if.sv ====
`timescale 1ns/1ps
interface mbs_rd_if;
  logic                      word_mode;
  logic [mbs_pkg::WORD_W-1:0] data;
  logic [mbs_pkg::WORD_W-1:0] mask;
  logic                      valid;
  logic                      clear;
  logic [mbs_pkg::SUM_W-1:0]  sum;
  modport acc (input word_mode, data, mask, valid, clear, output sum);
  modport ctl (output word_mode, data, mask, valid, clear, input sum);
endinterface : mbs_rd_if

// ==== verif/mbs_mem_model.sv ====
`timescale 1ns/1ps
module mbs_mem_model #(
  parameter logic [31:0] IDENT_WORD = 32'h2468ace1 // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_word,
  input  wire logic [31:0] mem_index,
  output logic             mem_valid,
  output logic [31:0]      mem_data
);
  // ----------------------------------------
  // flash and identity read path
  // ----------------------------------------
  logic        gap_q   = 1'b0;
  logic [2:0]  nword_q = 3'h0;
  logic [31:0] last_q  = 32'h0;
  function automatic logic [7:0] byte_at(input logic [31:0] i);
    return 8'hf7 ^ i[7:0];
  endfunction : byte_at
  // words 0..3 are config words, word 4 the identity word
  function automatic logic [31:0] word_at(input logic [2:0] k);
    return (k == 3'h4) ? IDENT_WORD : 32'hf0e1d2c3 ^ {4{5'h0, k}};
  endfunction : word_at
  assign mem_valid = mem_req & ~(slow & gap_q);
  // idle bus shows inverted last value so stale data never matches
  always_comb begin
    if (!mem_valid)
      mem_data = ~last_q;
    else if (mem_word)
      mem_data = word_at(nword_q);
    else
      mem_data = {~mem_index[23:0], byte_at(mem_index)};
  end
  always_ff @(posedge ref_clk) begin
    gap_q  <= ~gap_q;
    last_q <= mem_data;
    if (!mem_req)
      nword_q <= 3'h0;
    else if (mem_valid && mem_word)
      nword_q <= nword_q + 3'h1;
  end
endmodule : mbs_mem_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // clock, masks and instances
  // ----------------------------------------
  localparam logic [4:0][31:0] MASKS = {32'h000ff000, 32'h0000ffff,
    32'h00070077, 32'h009ff7a7, 32'h110ff00b};
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        start   = 1'b0;
  logic        prot    = 1'b0;
  logic        slow    = 1'b0;
  logic        ce      = 1'b1;
  logic        mem_req, mem_word, mem_valid, busy, done;
  logic [31:0] mem_index, mem_data, checksum;
  int          errors     = 0;
  int          n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  mbs_checksum #(.PROG_BYTES(8), .BOOT_BYTES(20), .CFG0_MASK(MASKS[0]),
    .CFG1_MASK(MASKS[1]), .CFG2_MASK(MASKS[2]), .CFG3_MASK(MASKS[3]),
    .IDENT_MASK(MASKS[4])) i_mbs_checksum (.ref_clk(ref_clk), .rst(rst),
    .ce(ce), .start(start), .code_protected(prot), .mem_req(mem_req),
    .mem_word(mem_word), .mem_index(mem_index), .mem_valid(mem_valid),
    .mem_data(mem_data), .busy(busy), .done(done), .checksum(checksum));
  mbs_mem_model i_mbs_mem_model (.ref_clk(ref_clk), .slow(slow),
    .mem_req(mem_req), .mem_word(mem_word), .mem_index(mem_index),
    .mem_valid(mem_valid), .mem_data(mem_data));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] expect_sum();
    logic [31:0] s;
    logic [31:0] w;
    s = 32'h0;
    for (int i = 0; i < 12; i++)
      s = s + 32'(i_mbs_mem_model.byte_at(32'(i < 8 ? i : i - 8)));
    for (int k = 0; k < 5; k++) begin
      w = i_mbs_mem_model.word_at(3'(k)) & MASKS[k];
      s = s + 32'(w[7:0]) + 32'(w[15:8]) + 32'(w[23:16]) + 32'(w[31:24]);
    end
    return ~s + 32'h1;
  endfunction : expect_sum
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp32(input string nm, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp32
  // bounded wait for done, then pulse width and hold of the result;
  // hold > 0 drops the clock enable for that many cycles on the first program read
  task automatic do_run(input logic p, input logic s, input int hold,
                        output logic [31:0] r);
    int          n;
    logic [31:0] ix;
    prot  = p;
    slow  = s;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    cmp32("busy", 32'h1, 32'(busy));
    if (hold > 0) begin
      ce = 1'b0;
      ix = mem_index;
      repeat (hold) @(negedge ref_clk);
      cmp32("index_frozen", ix, mem_index);
      cmp32("busy_frozen", 32'h1, 32'(busy));
      ce = 1'b1;
    end
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    if (done !== 1'b1) begin
      errors++;
      end_of_test();
    end
    r = checksum;
    cmp32("busy_at_done", 32'h0, 32'(busy));
    @(negedge ref_clk);
    cmp32("done_width", 32'h0, 32'(done));
    cmp32("checksum_hold", r, checksum);
  endtask : do_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_prompt();
    logic [31:0] r;
    do_run(1'b0, 1'b0, 0, r);
    cmp32("checksum", expect_sum(), r);
  endtask : t_prompt
  task automatic t_slow();
    logic [31:0] r;
    do_run(1'b0, 1'b1, 0, r);
    cmp32("checksum_slow", expect_sum(), r);
  endtask : t_slow
  task automatic t_freeze();
    logic [31:0] r;
    do_run(1'b0, 1'b0, 5, r);
    cmp32("checksum_freeze", expect_sum(), r);
  endtask : t_freeze
  task automatic t_protected();
    logic [31:0] r;
    do_run(1'b1, 1'b0, 0, r);
    cmp32("checksum_prot", 32'h0, r);
  endtask : t_protected
  task automatic t_reset();
    start = 1'b1;
    repeat (4) @(negedge ref_clk);
    start = 1'b0;
    rst   = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    cmp32("busy_rst", 32'h0, 32'(busy));
    cmp32("mem_req_rst", 32'h0, 32'(mem_req));
    cmp32("checksum_rst", 32'h0, checksum);
  endtask : t_reset
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_prompt();
    t_slow();
    t_freeze();
    t_protected();
    t_prompt();
    t_reset();
    t_prompt();
    end_of_test();
  end
endmodule : testbench
